//--- bbc_bridge.v
/*
  CPU bus cycle bridge: byte-wide internal bus with a 16-bit path for a
  subset of peripheral registers, region-dependent transfer length.
  Assumes the CPU and the memories run on CLK_IN and answer within the cycle.
*/
// Operation
// R1 - ROM, RAM and register space reach the CPU over a byte-wide path.
// R2 - A word on the byte path becomes two consecutive byte transfers.
// R3 - Register and data flash transfers take two CPU clock cycles.
// R4 - ROM and RAM transfers take one CPU clock cycle.
// R5 - A byte access drives its address once and moves one byte.
// R6 - Even word access drives even address, then even plus one.
// R7 - Odd word access drives odd address, then odd plus one, no penalty.
// R8 - Listed peripheral registers sit on a 16-bit path, words not split; odd-address words are split into two byte transfers here.
// R9 - Wide path word is one transfer, timed like an even register byte.
// R10 - Wide set: interrupt, timers, serial data, converter, address match registers.
// R11 - In split words the lower address carries the low byte.
// R12 - Region decoded from address; CPU stalled for the extra slow cycle.
`timescale 1ns/1ps
`include "bbc_map.vh"

module bbc_bridge #(
  parameter ADDR_W = 20
) (
  input wire CLK_IN,
  input wire SRST_IN,
  input wire CPU_REQ_IN,
  input wire CPU_WE_IN,
  input wire CPU_WORD_IN,
  input wire [ADDR_W-1:0] CPU_ADDR_IN,
  input wire [15:0] CPU_WDATA_IN,
  output reg CPU_READY_OUT,
  output reg CPU_DONE_OUT,
  output reg [15:0] CPU_RDATA_OUT,
  output reg [ADDR_W-1:0] MEM_ADDR_OUT,
  output reg [15:0] MEM_WDATA_OUT,
  output reg MEM_RD_OUT,
  output reg MEM_WR_OUT,
  output reg MEM_WIDE_OUT,
  output reg [1:0] MEM_REGION_OUT,
  input wire [15:0] MEM_RDATA_IN
);

  localparam ST_IDLE = 1'b0;
  localparam ST_XFER = 1'b1;

  reg state;
  reg [1:0] cnt;
  reg [1:0] len;
  reg second;
  reg beat;
  reg wr;
  reg [15:0] wdata;
  reg [15:0] rdata;

  reg next_state;
  reg [1:0] next_cnt;
  reg [1:0] next_len;
  reg next_second;
  reg next_beat;
  reg next_wr;
  reg [15:0] next_wdata;
  reg [15:0] next_rdata;
  reg next_ready;
  reg next_done;
  reg [15:0] next_cpu_rdata;
  reg [ADDR_W-1:0] next_addr;
  reg [15:0] next_mem_wdata;
  reg next_rd;
  reg next_mwr;
  reg next_wide;
  reg [1:0] next_region;

  wire [1:0] dec_region;
  wire dec_slow;
  wire dec_wide;
  wire [1:0] step_region;
  wire step_slow;
  wire [ADDR_W-1:0] addr_plus1;

  assign addr_plus1 = MEM_ADDR_OUT + {{(ADDR_W-1){1'b0}}, 1'b1};

  // Decode of the incoming request
  bbc_region_dec #(
    .ADDR_W(ADDR_W)
  ) u_dec_req (
    .addr_in(CPU_ADDR_IN),
    .region_out(dec_region),
    .slow_out(dec_slow),
    .wide_out(dec_wide)
  );

  // Second byte may cross into another region, so it is decoded afresh
  bbc_region_dec #(
    .ADDR_W(ADDR_W)
  ) u_dec_step (
    .addr_in(addr_plus1),
    .region_out(step_region),
    .slow_out(step_slow),
    .wide_out()
  );

  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_len = len;
    next_second = second;
    next_beat = beat;
    next_wr = wr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_ready = CPU_READY_OUT;
    next_done = 1'b0;
    next_cpu_rdata = CPU_RDATA_OUT;
    next_addr = MEM_ADDR_OUT;
    next_mem_wdata = MEM_WDATA_OUT;
    next_rd = MEM_RD_OUT;
    next_mwr = MEM_WR_OUT;
    next_wide = MEM_WIDE_OUT;
    next_region = MEM_REGION_OUT;
    case (state)
      ST_IDLE: begin
        if (CPU_REQ_IN && CPU_READY_OUT) begin
          next_state = ST_XFER;
          next_ready = 1'b0; // R12
          next_wr = CPU_WE_IN;
          next_wdata = CPU_WDATA_IN;
          next_rdata = `BBC_RST_DATA;
          next_addr = CPU_ADDR_IN; // R5 R6 R7
          next_region = dec_region;
          next_wide = CPU_WORD_IN & dec_wide; // R8 R9
          next_second = CPU_WORD_IN & ~dec_wide; // R2
          next_beat = 1'b0;
          next_len = dec_slow ? `BBC_SLOW_CYCLES : `BBC_FAST_CYCLES; // R3 R4
          next_cnt = next_len - 2'h1;
          next_rd = ~CPU_WE_IN;
          next_mwr = CPU_WE_IN;
          if (CPU_WORD_IN & dec_wide) begin
            next_mem_wdata = CPU_WDATA_IN; // R9
          end else begin
            next_mem_wdata = {8'h00, CPU_WDATA_IN[7:0]}; // R1 R11
          end
        end
      end
      ST_XFER: begin
        if (cnt != 2'h0) begin
          // Slow region holds the strobe for its extra cycle
          next_cnt = cnt - 2'h1; // R3 R12
        end else begin
          if (MEM_WIDE_OUT) begin
            next_rdata = MEM_RDATA_IN; // R9
          end else if (beat) begin
            next_rdata = {MEM_RDATA_IN[7:0], rdata[7:0]}; // R11
          end else begin
            next_rdata = {8'h00, MEM_RDATA_IN[7:0]}; // R1 R5
          end
          if (second) begin
            // Odd start costs nothing extra: same two transfers
            next_second = 1'b0;
            next_beat = 1'b1;
            next_addr = addr_plus1; // R6 R7
            next_region = step_region;
            next_len = step_slow ? `BBC_SLOW_CYCLES : `BBC_FAST_CYCLES; // R3 R4
            next_cnt = next_len - 2'h1;
            next_mem_wdata = {8'h00, wdata[15:8]}; // R11
          end else begin
            next_state = ST_IDLE;
            next_rd = 1'b0;
            next_mwr = 1'b0;
            next_wide = 1'b0;
            next_ready = 1'b1;
            next_done = 1'b1;
            next_cpu_rdata = wr ? CPU_RDATA_OUT : next_rdata;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_ready = 1'b1;
      end
    endcase
  end

  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state <= ST_IDLE;
      cnt <= 2'h0;
      len <= `BBC_FAST_CYCLES;
      second <= 1'b0;
      beat <= 1'b0;
      wr <= 1'b0;
      wdata <= `BBC_RST_DATA;
      rdata <= `BBC_RST_DATA;
      CPU_READY_OUT <= 1'b1;
      CPU_DONE_OUT <= 1'b0;
      CPU_RDATA_OUT <= `BBC_RST_DATA;
      MEM_ADDR_OUT <= `BBC_RST_ADDR;
      MEM_WDATA_OUT <= `BBC_RST_DATA;
      MEM_RD_OUT <= 1'b0;
      MEM_WR_OUT <= 1'b0;
      MEM_WIDE_OUT <= 1'b0;
      MEM_REGION_OUT <= `BBC_REG_ROM;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      len <= next_len;
      second <= next_second;
      beat <= next_beat;
      wr <= next_wr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      CPU_READY_OUT <= next_ready;
      CPU_DONE_OUT <= next_done;
      CPU_RDATA_OUT <= next_cpu_rdata;
      MEM_ADDR_OUT <= next_addr;
      MEM_WDATA_OUT <= next_mem_wdata;
      MEM_RD_OUT <= next_rd;
      MEM_WR_OUT <= next_mwr;
      MEM_WIDE_OUT <= next_wide;
      MEM_REGION_OUT <= next_region;
    end
  end

endmodule // bbc_bridge

//--- bbc_bridge_sva.sv
/* Port timing checker for bbc_bridge.
   Bound to every bbc_bridge instance. */
`timescale 1ns/1ps
`include "bbc_map.vh"
module bbc_bridge_sva #(parameter ADDR_W = 20) (
  input wire CLK_IN, SRST_IN, CPU_REQ_IN, CPU_READY_OUT, CPU_DONE_OUT, MEM_RD_OUT, MEM_WR_OUT, MEM_WIDE_OUT,
  input wire [ADDR_W-1:0] CPU_ADDR_IN, MEM_ADDR_OUT,
  input wire [1:0] MEM_REGION_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  wire [ADDR_W-1:0] a = MEM_ADDR_OUT;
  wire wr = a >= `BBC_W_IRQ_LO && a <= `BBC_W_IRQ_HI || a >= `BBC_W_PWM_LO && a <= `BBC_W_ADC_HI
    || a >= `BBC_W_AMT_LO && a <= `BBC_W_AMT_HI;
  first_beat_a: assert property (CPU_REQ_IN && CPU_READY_OUT |=> !CPU_READY_OUT && a == $past(CPU_ADDR_IN))
    else $error("bad first beat");
  next_beat_a: assert property (!CPU_READY_OUT && $past(!CPU_READY_OUT) && a != $past(a) |-> a == $past(a) + 1'b1)
    else $error("bad second beat");
  fast_beat_a: assert property ($fell(CPU_READY_OUT) && !MEM_REGION_OUT[1] |=> CPU_DONE_OUT || a != $past(a))
    else $error("fast beat too long");
  slow_beat_a: assert property ($fell(CPU_READY_OUT) && MEM_REGION_OUT[1]
    |=> (!CPU_DONE_OUT && $stable(a)) ##1 (CPU_DONE_OUT || a != $past(a)))
    else $error("slow beat length");
  wide_slot_a: assert property (MEM_WIDE_OUT |-> wr && !a[0] && MEM_REGION_OUT == `BBC_REG_SFR)
    else $error("wide outside set");
  wide_time_a: assert property ($fell(CPU_READY_OUT) && MEM_WIDE_OUT |-> ##2 CPU_DONE_OUT)
    else $error("wide length");
  done_pulse_a: assert property (CPU_DONE_OUT |=> !CPU_DONE_OUT)
    else $error("done too long");
  done_idle_a: assert property (CPU_DONE_OUT |-> CPU_READY_OUT && !MEM_RD_OUT && !MEM_WR_OUT)
    else $error("done while busy");
  wire [1:0] rg = (a <= `BBC_SFR_HI) ? `BBC_REG_SFR : (a >= `BBC_DFL_LO && a <= `BBC_DFL_HI) ? `BBC_REG_DFL
    : (a >= `BBC_RAM_LO && a <= `BBC_RAM_HI) ? `BBC_REG_RAM : `BBC_REG_ROM;
  region_map_a: assert property (MEM_RD_OUT || MEM_WR_OUT |-> MEM_REGION_OUT == rg)
    else $error("region does not match address");
  cover property (MEM_WIDE_OUT && CPU_DONE_OUT);
  cover property ($fell(CPU_READY_OUT) && MEM_REGION_OUT[1] ##2 a != $past(a));
  cover property (CPU_DONE_OUT ##1 $fell(CPU_READY_OUT));
endmodule // bbc_bridge_sva
bind bbc_bridge bbc_bridge_sva #(.ADDR_W(ADDR_W)) bbc_bridge_sva_inst (.*);

//--- bbc_map.vh
/*
  Address map, region codes and transfer lengths for the CPU bus cycle bridge.
  Assumes a flat CPU address space of 20 bits; included by its bare name.
*/
`ifndef BBC_MAP_VH
`define BBC_MAP_VH

// Region codes on the memory side
`define BBC_REG_ROM 2'h0
`define BBC_REG_RAM 2'h1
`define BBC_REG_SFR 2'h2
`define BBC_REG_DFL 2'h3

// Region bounds, inclusive
`define BBC_SFR_LO 20'h0_0000
`define BBC_SFR_HI 20'h0_02FF
`define BBC_RAM_LO 20'h0_0400
`define BBC_RAM_HI 20'h0_2BFF
`define BBC_DFL_LO 20'h0_3000
`define BBC_DFL_HI 20'h0_3FFF

// Registers that sit on the 16-bit path
`define BBC_W_IRQ_LO 20'h0_0040
`define BBC_W_IRQ_HI 20'h0_007F
`define BBC_W_PWM_LO 20'h0_0100
`define BBC_W_PWM_HI 20'h0_013F
`define BBC_W_ITM_LO 20'h0_0140
`define BBC_W_ITM_HI 20'h0_014F
`define BBC_W_SSU_LO 20'h0_0150
`define BBC_W_SSU_HI 20'h0_015F
`define BBC_W_ADC_LO 20'h0_0160
`define BBC_W_ADC_HI 20'h0_017F
`define BBC_W_AMT_LO 20'h0_01C0
`define BBC_W_AMT_HI 20'h0_01CF

// CPU clock cycles per transfer
`define BBC_SLOW_CYCLES 2'h2
`define BBC_FAST_CYCLES 2'h1

// Reset values
`define BBC_RST_ADDR 20'h0_0000
`define BBC_RST_DATA 16'h0000

`endif

//--- bbc_mem_model.sv
/* Memory side: byte store, read data in the same cycle.
   Assumes bridge strobes on clk_in. */
`timescale 1ns/1ps
module bbc_mem_model (
  input wire clk_in,
  input wire rd_in,
  input wire wr_in,
  input wire wide_in,
  input wire [19:0] addr_in,
  input wire [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  logic [7:0] mem [int];
  logic [7:0] junk = 8'h5A;
  function automatic logic [7:0] rb(logic [19:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ 8'hA5;
  endfunction
  always @(posedge clk_in) begin
    junk <= junk + 8'h3B;
    if (wr_in) mem[addr_in] = wdata_in[7:0];
    if (wr_in && wide_in) mem[addr_in + 1'b1] = wdata_in[15:8];
  end
  // Idle and upper byte lines move, so stale data cannot pass
  always @* rdata_out = !rd_in ? {junk, ~junk} : wide_in ? {rb(addr_in + 1'b1), rb(addr_in)} : {junk, rb(addr_in)};
endmodule // bbc_mem_model

//--- bbc_region_dec.v
/*
  Combinational region decoder for the CPU bus cycle bridge.
  Assumes the address is stable from the requesting logic on the same clock.
*/
`timescale 1ns/1ps
`include "bbc_map.vh"

module bbc_region_dec #(
  parameter ADDR_W = 20
) (
  input wire [ADDR_W-1:0] addr_in,
  output reg [1:0] region_out,
  output reg slow_out,
  output reg wide_out
);

  function in_range;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] lo;
    input [ADDR_W-1:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  always @* begin
    region_out = `BBC_REG_ROM;
    wide_out = 1'b0;
    if (in_range(addr_in, `BBC_SFR_LO, `BBC_SFR_HI)) begin
      region_out = `BBC_REG_SFR;
      // Only even addresses take the wide path
      wide_out = ~addr_in[0] &
        (in_range(addr_in, `BBC_W_IRQ_LO, `BBC_W_IRQ_HI) |
         in_range(addr_in, `BBC_W_PWM_LO, `BBC_W_PWM_HI) |
         in_range(addr_in, `BBC_W_ITM_LO, `BBC_W_ITM_HI) |
         in_range(addr_in, `BBC_W_SSU_LO, `BBC_W_SSU_HI) |
         in_range(addr_in, `BBC_W_ADC_LO, `BBC_W_ADC_HI) |
         in_range(addr_in, `BBC_W_AMT_LO, `BBC_W_AMT_HI)); // R8 R10
    end else if (in_range(addr_in, `BBC_DFL_LO, `BBC_DFL_HI)) begin
      region_out = `BBC_REG_DFL;
    end else if (in_range(addr_in, `BBC_RAM_LO, `BBC_RAM_HI)) begin
      region_out = `BBC_REG_RAM;
    end
    slow_out = (region_out == `BBC_REG_SFR) || (region_out == `BBC_REG_DFL); // R3 R12
  end

endmodule // bbc_region_dec

//--- tb.sv
/* Bench for bbc_bridge: latency and read-back.
   Assumes bbc_mem_model on the memory side. */
`timescale 1ns/1ps
`include "bbc_map.vh"
module tb;
  logic CLK_IN = 0, SRST_IN = 1, CPU_REQ_IN = 0, CPU_WE_IN = 0, CPU_WORD_IN = 0;
  logic [19:0] CPU_ADDR_IN = 0;
  logic [15:0] CPU_WDATA_IN = 0;
  wire CPU_READY_OUT, CPU_DONE_OUT, MEM_RD_OUT, MEM_WR_OUT, MEM_WIDE_OUT;
  wire [15:0] CPU_RDATA_OUT, MEM_WDATA_OUT, MEM_RDATA_IN;
  wire [19:0] MEM_ADDR_OUT;
  wire [1:0] MEM_REGION_OUT;
  typedef struct {logic [15:0] d; bit rd; int t;} bbc_note_t;
  bbc_note_t q[$];
  bbc_note_t m;
  logic [7:0] sh [int];
  logic [19:0] pts [16] = '{20'h0_0010, 20'h0_0021, 20'h0_0040, 20'h0_0041, 20'h0_017E, 20'h0_01CE, 20'h0_0146,
    20'h0_0156, 20'h0_0120, 20'h0_0180, 20'h0_02FF, 20'h0_0400, 20'h0_2BFF, 20'h0_3000, 20'h0_3FFF, 20'h0_8001};
  int fails = 0, checks = 0, cyc = 0;
  bbc_bridge bbc_bridge_inst (.*);
  bbc_mem_model bbc_mem_model_inst (.clk_in(CLK_IN), .rd_in(MEM_RD_OUT), .wr_in(MEM_WR_OUT), .wide_in(MEM_WIDE_OUT),
    .addr_in(MEM_ADDR_OUT), .wdata_in(MEM_WDATA_OUT), .rdata_out(MEM_RDATA_IN));
  always #4 CLK_IN = ~CLK_IN;
  always @(posedge CLK_IN) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      fails++;
      test_done();
    end
  end
  function automatic int bt(logic [19:0] a);
    return (a <= `BBC_SFR_HI || a >= `BBC_DFL_LO && a <= `BBC_DFL_HI) ? 2 : 1;
  endfunction
  function automatic bit wd(logic [19:0] a);
    return !a[0] && (a >= `BBC_W_IRQ_LO && a <= `BBC_W_IRQ_HI || a >= `BBC_W_PWM_LO && a <= `BBC_W_ADC_HI
      || a >= `BBC_W_AMT_LO && a <= `BBC_W_AMT_HI);
  endfunction
  function automatic logic [7:0] sb(logic [19:0] a);
    return sh.exists(a) ? sh[a] : a[7:0] ^ 8'hA5;
  endfunction
  task automatic chk(string s, logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask
  // Request stays up while busy, so refusal is exercised too
  task automatic acc(bit w, bit wo, logic [19:0] a);
    bbc_note_t n;
    logic [15:0] v;
    v = 16'($urandom);
    n.rd = !w;
    n.t = wo ? (wd(a) ? 2 : bt(a) + bt(a + 1'b1)) : bt(a);
    n.d = wo ? {sb(a + 1'b1), sb(a)} : {8'h00, sb(a)};
    if (w) sh[a] = v[7:0];
    if (w && wo) sh[a + 1'b1] = v[15:8];
    {CPU_REQ_IN, CPU_WE_IN, CPU_WORD_IN, CPU_ADDR_IN, CPU_WDATA_IN} = {1'b1, w, wo, a, v};
    do @(negedge CLK_IN); while (CPU_READY_OUT !== 1'b1);
    n.t += cyc + 1;
    q.push_back(n);
    @(posedge CLK_IN);
    #1;
  endtask
  always @(negedge CLK_IN) if (CPU_DONE_OUT === 1'b1) begin
    if (q.size() > 0) m = q.pop_front();
    else m = '{16'h0000, 1'b0, -1};
    chk("cycles", cyc, m.t);
    if (m.rd) chk("rdata", CPU_RDATA_OUT, m.d);
  end
  task automatic test_done();
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h0000_3FA4));
    repeat (5) @(posedge CLK_IN);
    #1 SRST_IN = 0;
    for (int i = 0; i < 16; i++) for (int k = 0; k < 5; k++) acc(k == 0 || k == 2, k != 2 && k != 3, pts[i]);
    CPU_REQ_IN = 0;
    repeat (60) begin
      repeat (1 + $urandom_range(1)) @(posedge CLK_IN);
      #1 acc(1'($urandom), 1'($urandom), 20'($urandom_range(20'h0_4FFF)));
      CPU_REQ_IN = 0;
    end
    // Reset during a slow split read must drop it and leave the bus idle
    @(posedge CLK_IN);
    #1 acc(1'b0, 1'b1, 20'h0_3001);
    SRST_IN = 1;
    q.delete();
    @(posedge CLK_IN);
    #1 SRST_IN = 0;
    chk("reset strobes", {CPU_READY_OUT, CPU_DONE_OUT, MEM_RD_OUT, MEM_WR_OUT, MEM_WIDE_OUT}, 5'h10);
    chk("reset addr", MEM_ADDR_OUT, `BBC_RST_ADDR);
    chk("reset rdata", CPU_RDATA_OUT, `BBC_RST_DATA);
    acc(1'b0, 1'b1, 20'h0_3001);
    CPU_REQ_IN = 0;
    repeat (10) @(posedge CLK_IN);
    chk("pending", q.size(), 0);
    test_done();
  end
endmodule // tb
